// ---- dv/tcr_csrs_properties.sv ----
// Port checks for the timer, counter and reset bank.
module tcr_csrs_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Host bus
    input wire logic hst_valid,
    input wire tcr_pkg::tcr_req_t hst_req,
    input wire logic hst_ack,
    input wire logic [31:0] hst_rdata,
    // Loader
    input wire logic eel_wr_valid,
    input wire logic eel_ack,
    input wire logic eel_done,
    // Resets and status
    input wire logic vphy_reset,
    input wire logic port1_phy_reset,
    input wire logic port2_phy_reset,
    input wire logic chip_soft_reset,
    input wire logic eeprom_abort,
    input wire logic eeprom_reload,
    input wire logic dev_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // High-time counts of the port resets
    logic [11:0] p1_cnt_r;
    logic [11:0] p2_cnt_r;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            p1_cnt_r <= 12'h000;
            p2_cnt_r <= 12'h000;
        end else begin
            p1_cnt_r <= port1_phy_reset ? p1_cnt_r + 12'h001 : 12'h000;
            p2_cnt_r <= port2_phy_reset ? p2_cnt_r + 12'h001 : 12'h000;
        end
    end
    // Host asks for a chip reset while running
    sequence chip_req_s;
        hst_valid && hst_req.wr && hst_req.addr == 9'h1F8
            && hst_req.wdata[0] && dev_ready;
    endsequence
    // Abort and not ready, then chip reset out
    sequence chip_go_s;
        eeprom_abort && !dev_ready ##1 chip_soft_reset;
    endsequence
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    ack_follows_a: assert property (hst_valid |=> hst_ack)
        else $error("host answer missing");
    ack_cause_a: assert property (hst_ack |-> $past(hst_valid))
        else $error("answer without request");
    rdata_idle_a: assert property (!hst_ack |-> hst_rdata == 32'h0)
        else $error("read data outside answer");
    vphy_hold_a: assert property ($rose(vphy_reset) |->
        vphy_reset [*4] ##1 !vphy_reset) else $error("vphy hold wrong");
    port1_hold_a: assert property ($fell(port1_phy_reset) |->
        p1_cnt_r == 12'h9F6) else $error("port1 hold wrong");
    port2_hold_a: assert property ($fell(port2_phy_reset) |->
        p2_cnt_r == 12'h9F6) else $error("port2 hold wrong");
    host_only_a: assert property (($rose(vphy_reset) ||
        $rose(port1_phy_reset) || $rose(port2_phy_reset)) |->
        $past(hst_valid, 2)) else $error("reset without host write");
    chip_start_a: assert property (chip_req_s |=> chip_go_s)
        else $error("chip reset start wrong");
    chip_reload_a: assert property ($rose(chip_soft_reset) |->
        ##[14:18] eeprom_reload) else $error("reload missing");
    ready_cause_a: assert property ($rose(dev_ready) |->
        $past(eel_done)) else $error("ready without loader done");
    loader_ack_a: assert property (eel_wr_valid |=> eel_ack)
        else $error("loader answer missing");
endmodule

bind tcr_timer_counter_reset_csrs tcr_csrs_properties tcr_csrs_properties_inst (
    .ref_clk(ref_clk), .rstn(rstn), .hst_valid(hst_valid),
    .hst_req(hst_req), .hst_ack(hst_ack), .hst_rdata(hst_rdata),
    .eel_wr_valid(eel_wr_valid), .eel_ack(eel_ack), .eel_done(eel_done),
    .vphy_reset(vphy_reset), .port1_phy_reset(port1_phy_reset),
    .port2_phy_reset(port2_phy_reset), .chip_soft_reset(chip_soft_reset),
    .eeprom_abort(eeprom_abort), .eeprom_reload(eeprom_reload),
    .dev_ready(dev_ready)
);

// ---- dv/tcr_host_model.sv ----
// Host model issuing register requests and noting expected reads.
module tcr_host_model (
    // Clock
    input wire logic ref_clk,
    // Request and answer
    output logic hst_valid,
    output tcr_pkg::tcr_req_t hst_req,
    input wire logic hst_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // Expected answers, bit 32 marks a checked read
    logic [32:0] exp_q[$];
    initial begin
        hst_valid = 1'b0;
        hst_req = '0;
    end
    // One pulse request; idle bus shows inverted junk
    task automatic acc(input logic wr, input logic [8:0] a,
                       input logic [31:0] d, input logic [1:0] h,
                       input logic [32:0] e);
        hst_req = '{wr, a, d, h[1], h[0]};
        hst_valid = 1'b1;
        exp_q.push_back(e);
        @(negedge ref_clk);
        hst_valid = 1'b0;
        hst_req = tcr_pkg::tcr_req_t'(~hst_req);
        // Answer due from the taking edge, checked at the next falling edge
        if (hst_ack !== 1'b1) begin
            testbench.n_fail++;
            testbench.conclude();
        end
        @(negedge ref_clk);
    endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the timer, counter and reset bank.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic hst_valid, hst_ack, eel_wr_valid, eel_ack, eel_done;
    tcr_pkg::tcr_req_t hst_req;
    logic [31:0] hst_rdata;
    logic timer_enable;
    logic [15:0] timer_preload;
    logic vphy_reset, port1_phy_reset, port2_phy_reset, chip_soft_reset;
    logic eeprom_abort, eeprom_reload, dev_ready;
    int n_fail = 0;
    int tests_run = 0;
    int unsigned cyc;
    logic [32:0] e;
    always #20 ref_clk = ~ref_clk;
    // Bench copy of the free counter
    always @(posedge ref_clk or negedge rstn) cyc <= !rstn ? 0 : cyc + 1;
    tcr_timer_counter_reset_csrs tcr_timer_counter_reset_csrs_inst (
        .ref_clk(ref_clk), .rstn(rstn), .hst_valid(hst_valid),
        .hst_req(hst_req), .hst_ack(hst_ack), .hst_rdata(hst_rdata),
        .eel_wr_valid(eel_wr_valid), .eel_ack(eel_ack),
        .eel_done(eel_done), .timer_enable(timer_enable),
        .timer_preload(timer_preload), .vphy_reset(vphy_reset),
        .port1_phy_reset(port1_phy_reset),
        .port2_phy_reset(port2_phy_reset),
        .chip_soft_reset(chip_soft_reset), .eeprom_abort(eeprom_abort),
        .eeprom_reload(eeprom_reload), .dev_ready(dev_ready));
    tcr_host_model tcr_host_model_inst (.ref_clk(ref_clk),
        .hst_valid(hst_valid), .hst_req(hst_req), .hst_ack(hst_ack));
    // Verdict and end of run
    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Read data comparison
    task automatic cmp(input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] %0t exp %h got %h", $time, x, g);
        end
    endtask
    // Bus shorthands
    task automatic rd(input logic [8:0] a, input logic [1:0] h,
                      input logic [31:0] x);
        tcr_host_model_inst.acc(1'b0, a, 32'h0, h, {1'b1, x});
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        tcr_host_model_inst.acc(1'b1, a, d, 2'b00, 33'h0);
    endtask
    // Signal picker for bounded waits
    function automatic logic pick(input int s);
        return s == 0 ? dev_ready : s == 1 ? port1_phy_reset : eeprom_reload;
    endfunction
    task automatic wt(input int s, input logic lvl);
        for (int i = 0; i < 3000 && pick(s) !== lvl; i++) @(negedge ref_clk);
        if (pick(s) !== lvl) begin
            n_fail++;
            conclude();
        end
    endtask
    // Oldest note against each answer
    always @(negedge ref_clk) begin
        if (hst_ack === 1'b1) begin
            e = tcr_host_model_inst.exp_q.pop_front();
            if (e[32]) cmp(e[31:0], hst_rdata);
        end
    end
    // Main sequence
    initial begin
        logic [15:0] pl;
        eel_wr_valid = 1'b0;
        eel_done = 1'b0;
        timer_enable = 1'b0;
        timer_preload = 16'hFFFF;
        pl = 16'($urandom(32'h4987));
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        // Only permitted registers before ready
        rd(9'h1F8, 2'b00, 32'h0);
        rd(9'h064, 2'b00, 32'h8765_4321);
        eel_done = 1'b1;
        wt(0, 1'b1);
        eel_done = 1'b0;
        rd(9'h090, 2'b00, 32'h0000_FFFF);
        rd(9'h09C, 2'b00, cyc);
        rd(9'h09C, 2'b00, cyc);
        rd(9'h100, 2'b00, 32'h0);
        for (int i = 0; i < 4; i++) begin
            pl = 16'($urandom);
            timer_preload = pl;
            @(negedge ref_clk);
            wr(9'h090, 32'h0);
            rd(9'h090, 2'b10, {16'h0, pl});
            rd(9'h090, 2'b11, 32'h0);
        end
        // Enabled timer steps down once per 25-cycle tick
        pl = 16'($urandom) | 16'h0001;
        timer_preload = pl;
        @(negedge ref_clk);
        for (int i = 0; i < 30 && cyc % 25 != 1; i++) @(negedge ref_clk);
        if (cyc % 25 != 1) begin
            n_fail++;
            conclude();
        end
        timer_enable = 1'b1;
        rd(9'h090, 2'b00, {16'h0, pl});
        repeat (24) @(negedge ref_clk);
        rd(9'h090, 2'b00, {16'h0, pl - 16'h0001});
        timer_enable = 1'b0;
        wr(9'h1F8, 32'hFFFF_FFF0);
        rd(9'h1F8, 2'b00, 32'h0);
        wr(9'h1F8, 32'h0000_000E);
        rd(9'h1F8, 2'b00, 32'h0000_000E);
        wr(9'h1F8, 32'h0);
        wr(9'h1F8, 32'h0000_0002);
        rd(9'h1F8, 2'b10, 32'h0000_0006);
        rd(9'h1F8, 2'b11, 32'h0);
        eel_wr_valid = 1'b1;
        @(negedge ref_clk);
        eel_wr_valid = 1'b0;
        wt(1, 1'b0);
        rd(9'h1F8, 2'b00, 32'h0);
        wr(9'h1F8, 32'h0000_0002);
        wr(9'h1F8, 32'h0000_0001);
        rd(9'h1F8, 2'b00, 32'h0000_0003);
        rd(9'h09C, 2'b00, 32'h0);
        rd(9'h064, 2'b00, 32'h0);
        rd(9'h090, 2'b00, 32'h0000_FFFF);
        wr(9'h1F8, 32'h0000_0001);
        wt(2, 1'b1);
        eel_done = 1'b1;
        wt(0, 1'b1);
        eel_done = 1'b0;
        rd(9'h064, 2'b00, 32'h8765_4321);
        rd(9'h1F8, 2'b00, 32'h0000_0002);
        wt(1, 1'b0);
        conclude();
    end
endmodule

// ---- hdl/tcr_hold_timer.sv ----
// One self-clearing reset bit with a minimum hold count.
module tcr_hold_timer #(
    parameter int HOLD_CYC = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Start request, ignored while busy
    input wire logic start,
    // Reset active, also the bit's read value
    output logic busy_r
);

    // Cycles left in the hold
    logic [tcr_pkg::TCR_CNT_W-1:0] cnt_r;

    // Hold counter: loads on start, runs down to zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (start && !busy_r) begin
            // Hold lasts exactly HOLD_CYC cycles
            cnt_r <= tcr_pkg::TCR_CNT_W'(HOLD_CYC - 1);
        end else if (busy_r && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Busy flag: set on start, clears itself at the end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy_r <= 1'b0;
        end else if (start && !busy_r) begin
            busy_r <= 1'b1;
        end else if (busy_r && cnt_r == '0) begin
            // Self-clear on release
            busy_r <= 1'b0;
        end
    end

endmodule

// ---- hdl/tcr_timer_counter_reset_csrs.sv ----
// Timer count, free-running counter and soft reset control registers.
module tcr_timer_counter_reset_csrs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Host register access from the serial management logic
    input wire logic hst_valid,
    input wire tcr_pkg::tcr_req_t hst_req,
    output logic hst_ack,
    output logic [31:0] hst_rdata,
    // Configuration loader write access
    input wire logic eel_wr_valid,
    output logic eel_ack,
    input wire logic eel_done,
    // Interval timer configuration
    input wire logic timer_enable,
    input wire logic [15:0] timer_preload,
    // Reset outputs
    output logic vphy_reset,
    output logic port1_phy_reset,
    output logic port2_phy_reset,
    output logic chip_soft_reset,
    // Loader control and readiness
    output logic eeprom_abort,
    output logic eeprom_reload,
    output logic dev_ready
);

    // Decoded host accesses
    logic hst_wr;
    logic hst_rd;
    logic sel_soft_reset;

    // Start requests for each reset bit
    logic start_chip;
    logic start_port1;
    logic start_port2;
    logic start_vphy;

    // Busy flags from the hold timers
    logic chip_busy;
    logic port1_busy;
    logic port2_busy;
    logic vphy_busy;

    // Chip reset sequence state
    tcr_pkg::tcr_state_t state_r;
    tcr_pkg::tcr_state_t state_nxt;

    // Counters
    logic [31:0] free_run_r;
    logic [15:0] timer_count_r;
    logic [tcr_pkg::TCR_CNT_W-1:0] tick_cnt_r;
    logic tick_r;

    // Read data before the half select
    logic [31:0] rd_word;
    logic [31:0] rd_out;

    // Chip-wide reset in force for this bank
    logic chip_hold;

    // Access decode
    assign hst_wr = hst_valid && hst_req.wr;
    assign hst_rd = hst_valid && !hst_req.wr;
    assign sel_soft_reset = (hst_req.addr == tcr_pkg::TCR_OFS_SOFT_RESET);

    // Only ones start a reset; zero writes do nothing
    assign start_chip = hst_wr && sel_soft_reset
        && hst_req.wdata[tcr_pkg::TCR_BIT_CHIP];
    assign start_port1 = hst_wr && sel_soft_reset
        && hst_req.wdata[tcr_pkg::TCR_BIT_PORT1];
    assign start_port2 = hst_wr && sel_soft_reset
        && hst_req.wdata[tcr_pkg::TCR_BIT_PORT2];
    assign start_vphy = hst_wr && sel_soft_reset
        && hst_req.wdata[tcr_pkg::TCR_BIT_VPHY];

    // Chip reset hold; a set bit ignores further writes
    tcr_hold_timer #(
        .HOLD_CYC(tcr_pkg::TCR_CHIP_HOLD_CYC)
    ) u_chip_hold (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(start_chip),
        .busy_r(chip_busy)
    );

    // Port one PHY reset, held the minimum time
    tcr_hold_timer #(
        .HOLD_CYC(tcr_pkg::TCR_PHY_HOLD_CYC)
    ) u_port1_hold (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(start_port1),
        .busy_r(port1_busy)
    );

    // Port two PHY reset, held the minimum time
    tcr_hold_timer #(
        .HOLD_CYC(tcr_pkg::TCR_PHY_HOLD_CYC)
    ) u_port2_hold (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(start_port2),
        .busy_r(port2_busy)
    );

    // Virtual PHY reset, short fixed pulse
    tcr_hold_timer #(
        .HOLD_CYC(tcr_pkg::TCR_VPHY_HOLD_CYC)
    ) u_vphy_hold (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(start_vphy),
        .busy_r(vphy_busy)
    );

    // Bank registers are held at defaults during chip reset
    assign chip_hold = chip_busy;

    // Next state of the chip reset sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            // Normal operation
            tcr_pkg::TCR_ST_RUN: begin
                if (start_chip) begin
                    state_nxt = tcr_pkg::TCR_ST_HOLD;
                end
            end
            // Chip held in reset
            tcr_pkg::TCR_ST_HOLD: begin
                if (!chip_busy) begin
                    // Released: loader reruns
                    state_nxt = tcr_pkg::TCR_ST_RELOAD;
                end
            end
            // Waiting for configuration loader
            tcr_pkg::TCR_ST_RELOAD: begin
                if (start_chip) begin
                    state_nxt = tcr_pkg::TCR_ST_HOLD;
                end else if (eel_done) begin
                    state_nxt = tcr_pkg::TCR_ST_RUN;
                end
            end
            default: begin
                state_nxt = tcr_pkg::TCR_ST_RUN;
            end
        endcase
    end

    // State register; power-up waits for the loader
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= tcr_pkg::TCR_ST_RELOAD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Ready flag follows the sequence state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dev_ready <= 1'b0;
        end else begin
            dev_ready <= (state_nxt == tcr_pkg::TCR_ST_RUN);
        end
    end

    // Abort pulse as a chip reset begins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            eeprom_abort <= 1'b0;
        end else begin
            // Stop any running EEPROM command
            eeprom_abort <= start_chip && !chip_busy;
        end
    end

    // Reload pulse as the chip leaves reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            eeprom_reload <= 1'b0;
        end else begin
            eeprom_reload <= (state_r == tcr_pkg::TCR_ST_HOLD)
                && (state_nxt == tcr_pkg::TCR_ST_RELOAD);
        end
    end

    // Reset outputs registered from the busy flags
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            chip_soft_reset <= 1'b0;
            port1_phy_reset <= 1'b0;
            port2_phy_reset <= 1'b0;
            vphy_reset <= 1'b0;
        end else begin
            // Chip reset does not drive the PHY resets
            chip_soft_reset <= chip_busy;
            port1_phy_reset <= port1_busy;
            port2_phy_reset <= port2_busy;
            vphy_reset <= vphy_busy;
        end
    end

    // Free-running counter
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            free_run_r <= tcr_pkg::TCR_FREE_RUN_RST;
        end else if (chip_hold) begin
            // Cleared one cycle after the reset write
            free_run_r <= tcr_pkg::TCR_FREE_RUN_RST;
        end else begin
            // Wraps to zero on overflow and keeps going
            free_run_r <= free_run_r + 32'h0000_0001;
        end
    end

    // Tick divider for the interval timer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r
                == tcr_pkg::TCR_CNT_W'(tcr_pkg::TCR_TICK_CYC - 1)) begin
            // One-cycle enable every tick period
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // Interval timer count
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            timer_count_r <= tcr_pkg::TCR_TIMER_COUNT_RST;
        end else if (chip_hold) begin
            // Default restored during chip reset
            timer_count_r <= tcr_pkg::TCR_TIMER_COUNT_RST;
        end else if (!timer_enable) begin
            // Halted timer sits at its preload
            timer_count_r <= timer_preload;
        end else if (tick_r) begin
            if (timer_count_r == 16'h0000) begin
                // Restart from preload after reaching zero
                timer_count_r <= timer_preload;
            end else begin
                // Counting down
                timer_count_r <= timer_count_r - 16'h0001;
            end
        end
    end

    // Register read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hst_req.addr == tcr_pkg::TCR_OFS_TIMER_COUNT) begin
            // Upper half reserved
            rd_word = {16'h0000, timer_count_r};
        end else if (hst_req.addr == tcr_pkg::TCR_OFS_FREE_RUN) begin
            rd_word = free_run_r;
        end else if (hst_req.addr == tcr_pkg::TCR_OFS_BYTE_TEST) begin
            // Pattern only once the chip is out of reset
            if (!chip_hold) begin
                rd_word = tcr_pkg::TCR_BYTE_TEST_VAL;
            end
        end else if (sel_soft_reset) begin
            // Bits read set while each reset is in force
            rd_word = {28'h0000000, vphy_busy, port2_busy,
                port1_busy, chip_busy};
        end
    end

    // Optional sixteen-bit half select
    always_comb begin
        rd_out = rd_word;
        if (hst_req.half_en) begin
            if (hst_req.half_hi) begin
                rd_out = {16'h0000, rd_word[31:16]};
            end else begin
                rd_out = {16'h0000, rd_word[15:0]};
            end
        end
    end

    // Host answer, one cycle after the request in any state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hst_ack <= 1'b0;
            hst_rdata <= 32'h0000_0000;
        end else begin
            hst_ack <= hst_valid;
            if (hst_rd) begin
                hst_rdata <= rd_out;
            end else begin
                hst_rdata <= 32'h0000_0000;
            end
        end
    end

    // Loader writes are acknowledged and dropped here
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            eel_ack <= 1'b0;
        end else begin
            // No path from the loader to any reset bit
            eel_ack <= eel_wr_valid;
        end
    end

endmodule

// ---- include/tcr_pkg.sv ----
// Constants, types and state codes of the timer, counter and reset bank.
// How it works
// - Count register shows sixteen-bit timer, resets FFFFh
// - Free counter starts zero, adds one per cycle
// - Free counter wraps to zero, stops only while held in chip reset
// - Free counter cleared within 160 ns of reset
// - Bit three resets virtual PHY, self-clears
// - Bit two holds port two PHY 102 us
// - Bit one holds port one PHY 102 us
// - Writes to a set reset bit ignored
// - Configuration loader cannot touch reset bits
// - Bit zero resets chip, self-clears on release
// - Chip reset reruns loader, spares PHY resets
// - Chip reset returns bank registers to defaults
// - Chip reset aborts any running EEPROM command
// - Reset control readable while device not ready
// - Either sixteen-bit half readable on its own
// - Enabled timer counts down from its preload
// - Byte order test returns pattern after reset
package tcr_pkg;

    // Register byte offsets
    localparam logic [8:0] TCR_OFS_TIMER_COUNT = 9'h090;
    localparam logic [8:0] TCR_OFS_FREE_RUN = 9'h09C;
    localparam logic [8:0] TCR_OFS_SOFT_RESET = 9'h1F8;
    localparam logic [8:0] TCR_OFS_BYTE_TEST = 9'h064;

    // Bit positions in the soft reset control register
    localparam int TCR_BIT_CHIP = 0;
    localparam int TCR_BIT_PORT1 = 1;
    localparam int TCR_BIT_PORT2 = 2;
    localparam int TCR_BIT_VPHY = 3;

    // Reset values
    localparam logic [15:0] TCR_TIMER_COUNT_RST = 16'hFFFF;
    localparam logic [31:0] TCR_FREE_RUN_RST = 32'h0000_0000;
    localparam logic [31:0] TCR_BYTE_TEST_VAL = 32'h8765_4321;

    // Clock rate and timing figures
    localparam int TCR_CLK_MHZ = 25;
    localparam int TCR_PHY_HOLD_NS = 102000;
    localparam int TCR_PHY_HOLD_CYC =
        (TCR_PHY_HOLD_NS * TCR_CLK_MHZ + 999) / 1000;
    localparam int TCR_VPHY_HOLD_NS = 160;
    localparam int TCR_VPHY_HOLD_CYC =
        (TCR_VPHY_HOLD_NS * TCR_CLK_MHZ + 999) / 1000;
    localparam int TCR_CHIP_HOLD_NS = 640;
    localparam int TCR_CHIP_HOLD_CYC =
        (TCR_CHIP_HOLD_NS * TCR_CLK_MHZ + 999) / 1000;
    localparam int TCR_TICK_NS = 1000;
    localparam int TCR_TICK_CYC = (TCR_TICK_NS * TCR_CLK_MHZ) / 1000;

    // Width of hold and tick counters
    localparam int TCR_CNT_W = 12;

    // Host register request
    typedef struct packed {
        logic wr;
        logic [8:0] addr;
        logic [31:0] wdata;
        logic half_en;
        logic half_hi;
    } tcr_req_t;

    // Chip-level reset sequence
    typedef enum logic [1:0] {
        TCR_ST_RUN = 2'b00,
        TCR_ST_HOLD = 2'b01,
        TCR_ST_RELOAD = 2'b10
    } tcr_state_t;

endpackage
